/* hw/secs_light_cond.v */
// Purpose: ambient light window condition evaluator
// Assumes: visible and infrared results valid with the done strobe
// Notes: entry and exit need a previous sample of the watched channel
`timescale 1ns/1ns
`include "secs_map.vh"
`default_nettype none
module secs_light_cond #(
   parameter W = 16
)
(
   // Clock and reset
   input wire i_clk,
   input wire i_rst_n,
   // Measurement
   input wire i_done,
   input wire [W-1:0] i_visible,
   input wire [W-1:0] i_infrared,
   input wire [W-1:0] i_low,
   input wire [W-1:0] i_high,
   input wire [2:0] i_select,
   input wire [1:0] i_enable,
   // Events
   output wire [1:0] o_hit
);
   reg vis_in_r;
   reg ir_in_r;
   reg valid_r;
   wire vis_in;
   wire ir_in;
   reg [1:0] hit;
   assign vis_in = (i_visible >= i_low) && (i_visible <= i_high);
   assign ir_in = (i_infrared >= i_low) && (i_infrared <= i_high);
   always @*
   begin
      hit = 2'h0;
      if (i_enable == 2'h1 && i_select == 3'h0)
         hit[0] = 1'b1;
      if (i_enable[0] && i_select[1:0] == 2'h1)
         hit[0] = valid_r && vis_in_r && !vis_in;
      if (i_enable[0] && i_select[1:0] == 2'h3)
         hit[0] = valid_r && ir_in_r && !ir_in;
      if (i_enable[1] && i_select[2:1] == 2'h2)
         hit[1] = valid_r && !vis_in_r && vis_in;
      if (i_enable[1] && i_select[2:1] == 2'h3)
         hit[1] = valid_r && !ir_in_r && ir_in;
   end
   assign o_hit = {2{i_done}} & hit;
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         vis_in_r <= 1'b0;
         ir_in_r <= 1'b0;
         valid_r <= 1'b0;
      end
      else if (i_done)
      begin
         vis_in_r <= vis_in;
         ir_in_r <= ir_in;
         valid_r <= 1'b1;
      end
   end
endmodule // secs_light_cond
`default_nettype wire

/* hw/secs_map.vh */
// Purpose: constants for the event condition select block
// Assumes: byte-wide register port, 25 MHz clock
// Notes: included by every design file
`ifndef SECS_MAP_VH
`define SECS_MAP_VH
`define SECS_ADDR_MODE_FIRST 8'h05
`define SECS_ADDR_MODE_SECOND 8'h06
`define SECS_MODE_FIRST_RESET 8'h00
`define SECS_MODE_SECOND_RESET 8'h00
`define SECS_MODE_FIRST_WMASK 8'hF7
`define SECS_MODE_SECOND_WMASK 8'h0F
`define SECS_PROX2_SEL_HI 7
`define SECS_PROX2_SEL_LO 6
`define SECS_PROX1_SEL_HI 5
`define SECS_PROX1_SEL_LO 4
`define SECS_LIGHT_SEL_HI 2
`define SECS_LIGHT_SEL_LO 0
`define SECS_CMD_SEL_HI 3
`define SECS_CMD_SEL_LO 2
`define SECS_PROX3_SEL_HI 1
`define SECS_PROX3_SEL_LO 0
`define SECS_SEL_DONE 2'h0
`define SECS_SEL_CROSS 2'h1
`define SECS_SEL_ABOVE 2'h3
`define SECS_CMD_ANY 2'h0
`define SECS_CMD_ERROR 2'h1
`endif

/* hw/secs_prox_cond.v */
// Purpose: one proximity channel condition evaluator
// Assumes: result and threshold valid with the done strobe
// Notes: crossing compares newest against previous result
`timescale 1ns/1ns
`include "secs_map.vh"
`default_nettype none
module secs_prox_cond #(
   parameter W = 16
)
(
   // Clock and reset
   input wire i_clk,
   input wire i_rst_n,
   // Measurement
   input wire i_done,
   input wire [W-1:0] i_result,
   input wire [W-1:0] i_threshold,
   input wire [1:0] i_select,
   // Event
   output wire o_hit
);
   reg prev_above_r;
   reg prev_valid_r;
   wire above;
   reg hit;
   assign above = i_result > i_threshold;
   always @*
   begin
      case (i_select)
         `SECS_SEL_DONE: hit = 1'b1;
         `SECS_SEL_CROSS: hit = prev_valid_r && (above != prev_above_r);
         `SECS_SEL_ABOVE: hit = above;
         default: hit = 1'b0;
      endcase
   end
   assign o_hit = i_done & hit;
   // Remember which side the last result lay on
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         prev_above_r <= 1'b0;
         prev_valid_r <= 1'b0;
      end
      else if (i_done)
      begin
         prev_above_r <= above;
         prev_valid_r <= 1'b1;
      end
   end
endmodule // secs_prox_cond
`default_nettype wire

/* hw/secs_top.v */
// Purpose: event condition selection for a proximity and light sensor
// Assumes: byte register port from the serial slave, same clock domain
// Notes: flags are sticky and cleared by writing ones to i_flag_clear
//
// Contract
// - Channel 2 selector bits 7:6, enable gated
// - Channel 2 00: flag every measurement
// - Channel 2 01: flag on threshold crossing
// - Channel 2 11: flag while above threshold
// - Channel 1 selector bits 5:4, enable gated
// - Channel 1 00: flag every measurement
// - Channel 1 01: flag on threshold crossing
// - Channel 1 11: flag while above threshold
// - Channel 3 selector second register bits 1:0
// - Channel 3 00: flag every measurement
// - Channel 3 01: flag on threshold crossing
// - Channel 3 11: flag while above threshold
// - Light selector bits 2:0 decoded with enables
// - Light enables and selector zero: no flags
// - Enable 01 selector 000: flag0 each sample
// - x01: visible leaving window sets flag0
// - x11: infrared leaving window sets flag0
// - 10x: visible entering window sets flag1
// - 11x: infrared entering window sets flag1
// - Command selector bits 3:2; 1x reserved
// - Command 00: flag on every response update
// - Command 01: flag on response with MSB
// - Output enabled: alert low on flag and enable
// - Flags sticky until host clears them
`timescale 1ns/1ns
`include "secs_map.vh"
`default_nettype none
module secs_top #(
   parameter W = 16
)
(
   // Clock and reset
   input wire i_clk,
   input wire i_rst_n,
   // Register port
   input wire i_reg_wr,
   input wire [7:0] i_reg_addr,
   input wire [7:0] i_reg_wdata,
   output reg [7:0] o_reg_rdata,
   // Enables and output control from the neighbouring registers
   input wire i_prox1_event_enable,
   input wire i_prox2_event_enable,
   input wire i_prox3_event_enable,
   input wire [1:0] i_light_event_enable,
   input wire i_command_event_enable,
   input wire i_alert_output_enable,
   // Flag clear, one bit per flag: cmd, p3, p2, p1, light[1:0]
   input wire [5:0] i_flag_clear,
   // Measurement results
   input wire i_prox1_done,
   input wire i_prox2_done,
   input wire i_prox3_done,
   input wire [W-1:0] i_prox1_result,
   input wire [W-1:0] i_prox2_result,
   input wire [W-1:0] i_prox3_result,
   input wire [W-1:0] i_prox1_threshold,
   input wire [W-1:0] i_prox2_threshold,
   input wire [W-1:0] i_prox3_threshold,
   input wire i_light_done,
   input wire [W-1:0] i_visible_light_result,
   input wire [W-1:0] i_infrared_light_result,
   input wire [W-1:0] i_light_window_low,
   input wire [W-1:0] i_light_window_high,
   // Response register update
   input wire i_response_wr,
   input wire [7:0] i_response_data,
   // Status and alert pin
   output reg o_prox1_event_flag,
   output reg o_prox2_event_flag,
   output reg o_prox3_event_flag,
   output reg [1:0] o_light_event_flags,
   output reg o_command_event_flag,
   output reg o_alert_out,
   output reg o_alert_oe
);
   reg [7:0] event_mode_first_r;
   reg [7:0] event_mode_second_r;
   wire [1:0] prox1_condition_select;
   wire [1:0] prox2_condition_select;
   wire [1:0] prox3_condition_select;
   wire [2:0] light_condition_select;
   wire [1:0] command_condition_select;
   wire p1_hit;
   wire p2_hit;
   wire p3_hit;
   wire [1:0] light_hit;
   reg cmd_hit;
   reg [5:0] flags_nxt;
   wire [5:0] flags_now;
   wire [5:0] enables;

   assign prox2_condition_select = event_mode_first_r[`SECS_PROX2_SEL_HI:`SECS_PROX2_SEL_LO];
   assign prox1_condition_select = event_mode_first_r[`SECS_PROX1_SEL_HI:`SECS_PROX1_SEL_LO];
   assign light_condition_select = event_mode_first_r[`SECS_LIGHT_SEL_HI:`SECS_LIGHT_SEL_LO];
   assign prox3_condition_select = event_mode_second_r[`SECS_PROX3_SEL_HI:`SECS_PROX3_SEL_LO];
   assign command_condition_select = event_mode_second_r[`SECS_CMD_SEL_HI:`SECS_CMD_SEL_LO];

   // Mode registers
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         event_mode_first_r <= `SECS_MODE_FIRST_RESET;
         event_mode_second_r <= `SECS_MODE_SECOND_RESET;
      end
      else if (i_reg_wr)
      begin
         if (i_reg_addr == `SECS_ADDR_MODE_FIRST)
            event_mode_first_r <= i_reg_wdata & `SECS_MODE_FIRST_WMASK;
         if (i_reg_addr == `SECS_ADDR_MODE_SECOND)
            event_mode_second_r <= i_reg_wdata & `SECS_MODE_SECOND_WMASK;
      end
   end

   // Read data, registered; unmapped addresses read zero
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_reg_rdata <= 8'h00;
      else if (i_reg_addr == `SECS_ADDR_MODE_FIRST)
         o_reg_rdata <= event_mode_first_r;
      else if (i_reg_addr == `SECS_ADDR_MODE_SECOND)
         o_reg_rdata <= event_mode_second_r;
      else
         o_reg_rdata <= 8'h00;
   end

   // Proximity evaluators, one per channel; crossing uses previous side of threshold
   wire [2:0] prox_done;
   wire [3*W-1:0] prox_result;
   wire [3*W-1:0] prox_threshold;
   wire [5:0] prox_select;
   wire [2:0] prox_hit;
   genvar g;
   assign prox_done = {i_prox3_done, i_prox2_done, i_prox1_done};
   assign prox_result = {i_prox3_result, i_prox2_result, i_prox1_result};
   assign prox_threshold = {i_prox3_threshold, i_prox2_threshold, i_prox1_threshold};
   assign prox_select = {prox3_condition_select, prox2_condition_select, prox1_condition_select};
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : g_prox
         secs_prox_cond #(.W(W)) u_prox (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_done(prox_done[g]),
            .i_result(prox_result[g*W +: W]),
            .i_threshold(prox_threshold[g*W +: W]),
            .i_select(prox_select[2*g +: 2]),
            .o_hit(prox_hit[g])
         );
      end
   endgenerate
   assign p1_hit = prox_hit[0];
   assign p2_hit = prox_hit[1];
   assign p3_hit = prox_hit[2];
   secs_light_cond #(.W(W)) u_light (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_done(i_light_done),
      .i_visible(i_visible_light_result),
      .i_infrared(i_infrared_light_result),
      .i_low(i_light_window_low),
      .i_high(i_light_window_high),
      .i_select(light_condition_select),
      .i_enable(i_light_event_enable),
      .o_hit(light_hit)
   );

   // Command condition; reserved patterns raise nothing
   always @*
   begin
      case (command_condition_select)
         `SECS_CMD_ANY: cmd_hit = i_response_wr;
         `SECS_CMD_ERROR: cmd_hit = i_response_wr & i_response_data[7];
         default: cmd_hit = 1'b0;
      endcase
   end

   assign flags_now = {o_command_event_flag, o_prox3_event_flag, o_prox2_event_flag,
                       o_prox1_event_flag, o_light_event_flags};
   assign enables = {i_command_event_enable, i_prox3_event_enable, i_prox2_event_enable,
                     i_prox1_event_enable, i_light_event_enable};

   // Sticky flags: a new event wins over a clear in the same cycle
   always @*
   begin
      flags_nxt = flags_now & ~i_flag_clear;
      flags_nxt[5] = flags_nxt[5] | (cmd_hit & i_command_event_enable);
      flags_nxt[4] = flags_nxt[4] | (p3_hit & i_prox3_event_enable);
      flags_nxt[3] = flags_nxt[3] | (p2_hit & i_prox2_event_enable);
      flags_nxt[2] = flags_nxt[2] | (p1_hit & i_prox1_event_enable);
      flags_nxt[1:0] = flags_nxt[1:0] | light_hit;
   end

   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_command_event_flag <= 1'b0;
         o_prox3_event_flag <= 1'b0;
         o_prox2_event_flag <= 1'b0;
         o_prox1_event_flag <= 1'b0;
         o_light_event_flags <= 2'h0;
         o_alert_out <= 1'b0;
         o_alert_oe <= 1'b0;
      end
      else
      begin
         o_command_event_flag <= flags_nxt[5];
         o_prox3_event_flag <= flags_nxt[4];
         o_prox2_event_flag <= flags_nxt[3];
         o_prox1_event_flag <= flags_nxt[2];
         o_light_event_flags <= flags_nxt[1:0];
         o_alert_out <= 1'b0;
         // Open drain: drive low only while an enabled flag stands
         o_alert_oe <= i_alert_output_enable && |(flags_nxt & enables);
      end
   end
endmodule // secs_top
`default_nettype wire

/* testbench/secs_host_model.sv */
// Purpose: host model for the mode registers
// Assumes: inputs change 1 ns after the edge
// Notes: released write data shows the inverse byte
`timescale 1ns/1ns
`include "secs_map.vh"
`default_nettype none
module secs_host_model
(
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   output logic o_wr,
   output logic [7:0] o_addr,
   output logic [7:0] o_wdata
);
   initial
   begin
      o_wr = 1'b0;
      o_addr = 8'h00;
      o_wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      if (a == `SECS_ADDR_MODE_SECOND)
         d[3] = 1'b0;
      @(posedge i_clk);
      #1;
      o_wr = 1'b1;
      o_addr = a;
      o_wdata = d;
      @(posedge i_clk);
      #1;
      o_wr = 1'b0;
      o_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_addr = a;
      @(posedge i_clk);
      #1;
      d = i_rdata;
   endtask
endmodule // secs_host_model
`default_nettype wire

/* testbench/secs_top_monitor.sv */
// Purpose: port assertions for the event condition block
// Assumes: mode registers mirrored from the write port
// Notes: bound into every top instance
`timescale 1ns/1ns
`include "secs_map.vh"
`default_nettype none
module secs_top_monitor #(
   parameter W = 16
)
(
   input wire logic i_clk, i_rst_n, i_reg_wr, i_prox1_done, i_prox2_done, i_light_done,
   input wire logic i_prox1_event_enable, i_prox2_event_enable, i_prox3_event_enable,
   input wire logic i_alert_output_enable, i_response_wr, o_prox1_event_flag, o_prox2_event_flag,
   input wire logic o_prox3_event_flag, o_command_event_flag, o_alert_out, o_alert_oe,
   input wire logic [7:0] i_reg_addr, i_reg_wdata, i_response_data,
   input wire logic [1:0] i_light_event_enable, o_light_event_flags,
   input wire logic [5:0] i_flag_clear,
   input wire logic [W-1:0] i_prox1_result, i_prox1_threshold
);
   logic [7:0] mode1_r;
   logic [7:0] mode2_r;
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         mode1_r <= 8'h00;
         mode2_r <= 8'h00;
      end
      else if (i_reg_wr && i_reg_addr == `SECS_ADDR_MODE_FIRST)
         mode1_r <= i_reg_wdata & `SECS_MODE_FIRST_WMASK;
      else if (i_reg_wr && i_reg_addr == `SECS_ADDR_MODE_SECOND)
         mode2_r <= i_reg_wdata & `SECS_MODE_SECOND_WMASK;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   chk_p2_gate: assert property ($rose(o_prox2_event_flag) |-> $past(i_prox2_done && i_prox2_event_enable))
      else $error("prox2 flag without enabled result");
   chk_p1_every: assert property (i_prox1_done && i_prox1_event_enable && mode1_r[5:4] == 2'h0
      |=> o_prox1_event_flag) else $error("prox1 done not flagged");
   chk_p1_above: assert property (i_prox1_done && i_prox1_event_enable && mode1_r[5:4] == 2'h3
      && i_prox1_result > i_prox1_threshold |=> o_prox1_event_flag) else $error("prox1 above not flagged");
   chk_p3_gate: assert property (!i_prox3_event_enable && !o_prox3_event_flag |=> !o_prox3_event_flag)
      else $error("prox3 flag while disabled");
   chk_light_every: assert property (i_light_done && i_light_event_enable == 2'h1 && mode1_r[2:0] == 3'h0
      |=> o_light_event_flags[0]) else $error("light sample not flagged");
   chk_cmd_error: assert property (i_response_wr && mode2_r[3:2] == 2'h1 && !i_response_data[7]
      && !o_command_event_flag |=> !o_command_event_flag) else $error("command flag without error code");
   chk_flag_sticky: assert property (o_prox2_event_flag && !i_flag_clear[3] |=> o_prox2_event_flag)
      else $error("prox2 flag dropped");
   chk_alert_drive: assert property (o_prox1_event_flag && !i_flag_clear[2] && i_prox1_event_enable
      && i_alert_output_enable |=> o_alert_oe && !o_alert_out) else $error("alert not driven");
   cover property ($rose(o_prox1_event_flag));
   cover property ($rose(o_light_event_flags[1]));
   cover property ($rose(o_command_event_flag));
endmodule // secs_top_monitor
bind secs_top secs_top_monitor #(.W(W)) i_monitor (.*);
`default_nettype wire

/* testbench/sensor_event_condition_select_tb.sv */
// Purpose: random self-checking bench for the event block
// Assumes: thresholds and window held constant
// Notes: a cycle model predicts every flag and the alert
`timescale 1ns/1ns
`include "secs_map.vh"
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
   $display("wrong value at %0t got %h exp %h", $time, a, b); end end
module sensor_event_condition_select_tb;
   localparam logic [15:0] LO = 16'h0010, HI = 16'h0028;
   // Distinct thresholds so a swapped threshold port shows up
   logic [15:0] th [3] = '{16'h0020, 16'h0018, 16'h0030};
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic wr, lds, rwr, cen, aoe, cf, oe, ao, eoe;
   logic [7:0] addr, wdata, rdata, resp, rb, m1, m2;
   logic [2:0] done, pen, pf;
   logic [1:0] len, lf;
   logic [5:0] clr, ef;
   logic [15:0] res [3];
   logic [15:0] vis, ir;
   int n_errors = 0;
   int samples_checked = 0;
   int pv [3];
   int hp [3];
   int pvis, pir, hl;
   secs_top #(.W(16)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_wr(wr), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_prox1_event_enable(pen[0]), .i_prox2_event_enable(pen[1]),
      .i_prox3_event_enable(pen[2]), .i_light_event_enable(len), .i_command_event_enable(cen),
      .i_alert_output_enable(aoe), .i_flag_clear(clr), .i_prox1_done(done[0]), .i_prox2_done(done[1]),
      .i_prox3_done(done[2]), .i_prox1_result(res[0]), .i_prox2_result(res[1]), .i_prox3_result(res[2]),
      .i_prox1_threshold(th[0]), .i_prox2_threshold(th[1]), .i_prox3_threshold(th[2]), .i_light_done(lds),
      .i_visible_light_result(vis), .i_infrared_light_result(ir), .i_light_window_low(LO),
      .i_light_window_high(HI), .i_response_wr(rwr), .i_response_data(resp), .o_prox1_event_flag(pf[0]),
      .o_prox2_event_flag(pf[1]), .o_prox3_event_flag(pf[2]), .o_light_event_flags(lf),
      .o_command_event_flag(cf), .o_alert_out(ao), .o_alert_oe(oe));
   secs_host_model i_host (.i_clk(i_clk), .i_rdata(rdata), .o_wr(wr), .o_addr(addr), .o_wdata(wdata));
   always #20 i_clk = ~i_clk;
   function automatic logic inw(int v);
      return v >= LO && v <= HI;
   endfunction
   task automatic conclude();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // One cycle of stimulus; act low leaves the event inputs idle
   task automatic cyc(input logic act);
      logic [5:0] s;
      logic [1:0] sel;
      s = 6'h00;
      {pen, len, cen, aoe} = 7'($urandom);
      done = act ? 3'($urandom) : 3'h0;
      lds = act & 1'($urandom);
      rwr = act & 1'($urandom);
      resp = 8'($urandom);
      clr = (act && $urandom % 8 == 0) ? 6'($urandom) : 6'h00;
      vis = 16'($urandom % 64);
      ir = 16'($urandom % 64);
      for (int k = 0; k < 3; k++)
      begin
         res[k] = 16'($urandom % 64);
         sel = k == 2 ? m2[1:0] : k == 1 ? m1[7:6] : m1[5:4];
         if (done[k] && pen[k] && (sel == 0 || (sel == 3 && res[k] > th[k])
            || (sel == 1 && hp[k] == 1 && (res[k] > th[k]) != (pv[k] > th[k]))))
            s[k + 2] = 1'b1;
         if (done[k])
            {pv[k], hp[k]} = {32'(res[k]), 32'd1};
      end
      if (lds && len == 2'h1 && m1[2:0] == 3'h0)
         s[0] = 1'b1;
      if (lds && len[0] && hl == 1 && m1[0] && inw(m1[1] ? pir : pvis) && !inw(m1[1] ? ir : vis))
         s[0] = 1'b1;
      if (lds && len[1] && hl == 1 && m1[2] && !inw(m1[1] ? pir : pvis) && inw(m1[1] ? ir : vis))
         s[1] = 1'b1;
      if (lds)
         {pvis, pir, hl} = {32'(vis), 32'(ir), 32'd1};
      if (rwr && cen && (m2[3:2] == 2'h0 || (m2[3:2] == 2'h1 && resp[7])))
         s[5] = 1'b1;
      ef = s | (ef & ~clr);
      eoe = aoe && |(ef & {cen, pen, len});
      @(posedge i_clk);
      #1;
      `CHK({cf, pf, lf}, ef)
      `CHK({ao, oe}, {1'b0, eoe})
   endtask
   initial
   begin
      {done, lds, rwr, clr, pen, len, cen, aoe, resp, vis, ir, ef, m1, m2} = '0;
      res = '{3{16'h0000}};
      void'($urandom(32'hE3127EB3));
      repeat (8) @(posedge i_clk);
      #1;
      i_rst_n = 1'b1;
      i_host.rd(`SECS_ADDR_MODE_FIRST, rb);
      `CHK(rb, `SECS_MODE_FIRST_RESET)
      for (int p = 0; p < 24; p++)
      begin
         m1 = 8'($urandom) & `SECS_MODE_FIRST_WMASK;
         m1[6] |= m1[7];
         m1[4] |= m1[5];
         m2 = 8'($urandom) & 8'h07;
         m2[0] |= m2[1];
         i_host.wr(`SECS_ADDR_MODE_FIRST, m1 | 8'h08);
         i_host.wr(`SECS_ADDR_MODE_SECOND, m2 | 8'hF0);
         i_host.rd(`SECS_ADDR_MODE_FIRST, rb);
         `CHK(rb, m1)
         i_host.rd(`SECS_ADDR_MODE_SECOND, rb);
         `CHK(rb, m2)
         i_host.rd(8'h07, rb);
         `CHK(rb, 8'h00)
         repeat (150) cyc(1'b1);
         cyc(1'b0);
      end
      conclude();
   end
   initial
   begin
      #(40 * 8000);
      n_errors++;
      conclude();
   end
endmodule // sensor_event_condition_select_tb
`default_nettype wire
